/* rtl/afs_pkg.sv */
// afs_pkg: register map, field layout and timing constants of the sequencer
`default_nettype none
package afs_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ACR = 8'h04;
  localparam logic [7:0] OFS_MR = 8'h08;
  localparam logic [7:0] OFS_CMP = 8'h0C;
  localparam logic [7:0] OFS_STS = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_DATA = 8'h18;
  // field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_FREE_BIT = 1;
  localparam int ACR_AMP0_BIT = 0;
  localparam int ACR_AMP1_BIT = 1;
  localparam int MR_DIV_LSB = 0;
  localparam int MR_TRK_LSB = 8;
  localparam int MR_AVG_BIT = 16;
  localparam int MR_OSR_LSB = 17;
  localparam int MR_LAST_LSB = 20;
  localparam int CMP_EN_BIT = 16;
  localparam int STS_EOC_BIT = 0;
  localparam int STS_MATCH_BIT = 1;
  localparam int STS_BUSY_BIT = 2;
  localparam int DATA_CH_LSB = 16;
  // writable bits and values after reset
  localparam logic [31:0] CTRL_MASK = 32'h0000_0002;
  localparam logic [31:0] ACR_MASK = 32'h0000_0003;
  localparam logic [31:0] MR_MASK = 32'h00FF_0FFF;
  localparam logic [31:0] CMP_MASK = 32'h0001_0FFF;
  localparam logic [31:0] IRQ_MASK = 32'h0000_0003;
  localparam logic [31:0] MR_RST = 32'h0000_0001;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;
  // timing in converter clock periods
  localparam int TRACK_MIN = 15;
  localparam int CONV_TICKS = 23;
  localparam int XFER_TICKS = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_XFER} afs_state_type;
endpackage
`default_nettype wire

/* rtl/afs_prescaler.sv */
// afs_prescaler: converter clock tick, one pulse every div+1 clocks
`default_nettype none
module afs_prescaler #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] div,
  output logic tick
);
  logic [W-1:0] cnt_q;

  initial begin
    if (W < 1 || W > 16) $error("afs_prescaler: W out of range");
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (cnt_q >= div) begin
      cnt_q <= '0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + W'(1);
      tick <= 1'b0;
    end
  end

  a_tick_period: assert property (@(posedge clk) disable iff (rst)
    (tick && div == W'(1)) ##1 (div == W'(1)) |-> !tick ##1 tick)
    else $error("converter tick period not two clocks at divider one");
endmodule // afs_prescaler
`default_nettype wire

/* rtl/afs_compare.sv */
// afs_compare: gated threshold comparison of a finished conversion
`default_nettype none
module afs_compare #(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] data,
  input wire logic [W-1:0] threshold,
  input wire logic enable,
  input wire logic valid,
  output logic match
);
  initial begin
    if (W < 1) $error("afs_compare: W must be positive");
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) match <= 1'b0;
    else match <= valid && enable && (data >= threshold);
  end

  a_cmp_gate: assert property (@(posedge clk) disable iff (rst)
    !enable |=> !match)
    else $error("comparison matched while disabled");
endmodule // afs_compare
`default_nettype wire

/* rtl/afs_sequencer.sv */
// afs_sequencer: converter sequencing, register slave, interrupt, fault
//
// What this block does
// - hold channel for transfer time after start
// - tracking lasts at least fifteen converter periods
// - next tracking overlaps the running conversion
// - long tracking waits for previous conversion end
// - converter clock is divided peripheral clock
// - each conversion takes twenty-three converter periods
// - averaging multiplies conversion time by 2**ratio
// - free running starts conversions back to back
// - comparison enable bit gates every match
// - fault output feeds the PWM fault input
`default_nettype none
module afs_sequencer #(
  parameter int AW = 8,
  parameter int DW = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [DW-1:0] conv_data,
  output logic [3:0] afe_channel,
  output logic afe_start,
  output logic irq,
  output logic fault
);
  initial begin
    if (AW < 8 || AW > 32) $error("afs_sequencer: AW out of range");
    if (DW < 1 || DW > 16) $error("afs_sequencer: DW out of range");
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb,
                                        input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r & msk;
  endfunction

  function automatic logic known(input logic [7:0] a);
    return a == afs_pkg::OFS_CTRL || a == afs_pkg::OFS_ACR ||
      a == afs_pkg::OFS_MR || a == afs_pkg::OFS_CMP ||
      a == afs_pkg::OFS_STS || a == afs_pkg::OFS_MASK ||
      a == afs_pkg::OFS_DATA;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus slave
  logic aw_full_q, w_full_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_en;
  logic rd_hs;
  logic [7:0] raddr;

  assign wr_en = aw_full_q && w_full_q && !s_axi_bvalid;
  assign rd_hs = s_axi_arvalid && s_axi_arready;
  assign raddr = {s_axi_araddr[7:2], 2'b00};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_full_q <= 1'b0;
      s_axi_awready <= 1'b0;
      waddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      s_axi_awready <= 1'b0;
      waddr_q <= {s_axi_awaddr[7:2], 2'b00};
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_full_q <= 1'b0;
    end else if (!aw_full_q && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_full_q <= 1'b0;
      s_axi_wready <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_full_q <= 1'b0;
    end else if (!w_full_q && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= afs_pkg::RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= known(waddr_q) ? afs_pkg::RESP_OKAY
                                    : afs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] ctrl_q, acr_q, mr_q, cmp_q, mask_q;
  logic [2:0] sts_q;
  logic [DW-1:0] data_q;
  logic [3:0] data_ch_q;
  logic busy;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= afs_pkg::ZERO_RST;
      acr_q <= afs_pkg::ZERO_RST;
      mr_q <= afs_pkg::MR_RST;
      cmp_q <= afs_pkg::ZERO_RST;
      mask_q <= afs_pkg::ZERO_RST;
    end else if (wr_en) begin
      unique case (waddr_q)
        afs_pkg::OFS_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q,
                                           afs_pkg::CTRL_MASK);
        afs_pkg::OFS_ACR: acr_q <= merge(acr_q, wdata_q, wstrb_q,
                                         afs_pkg::ACR_MASK);
        afs_pkg::OFS_MR: mr_q <= merge(mr_q, wdata_q, wstrb_q,
                                       afs_pkg::MR_MASK);
        afs_pkg::OFS_CMP: cmp_q <= merge(cmp_q, wdata_q, wstrb_q,
                                         afs_pkg::CMP_MASK);
        afs_pkg::OFS_MASK: mask_q <= merge(mask_q, wdata_q, wstrb_q,
                                           afs_pkg::IRQ_MASK);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= afs_pkg::RESP_OKAY;
    end else if (rd_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= known(raddr) ? afs_pkg::RESP_OKAY
                                  : afs_pkg::RESP_SLVERR;
      unique case (raddr)
        afs_pkg::OFS_CTRL: s_axi_rdata <= ctrl_q;
        afs_pkg::OFS_ACR: s_axi_rdata <= acr_q;
        afs_pkg::OFS_MR: s_axi_rdata <= mr_q;
        afs_pkg::OFS_CMP: s_axi_rdata <= cmp_q;
        afs_pkg::OFS_STS: s_axi_rdata <= {29'h0, sts_q};
        afs_pkg::OFS_MASK: s_axi_rdata <= mask_q;
        afs_pkg::OFS_DATA: s_axi_rdata <= {12'h000, data_ch_q,
                                           16'(data_q)};
        default: s_axi_rdata <= '0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  afs_pkg::afs_state_type st_q;
  logic tick, fire, conv_end, xfer_done, start_q, match;
  logic gains_on, free_run, avg_on;
  logic [4:0] trk_cnt_q, trk_len;
  logic [1:0] xfer_cnt_q;
  logic [11:0] conv_cnt_q, conv_len;
  logic [3:0] chan_q, conv_ch_q, last_ch;
  logic [DW-1:0] meta_q, sync_q;

  assign gains_on = acr_q[afs_pkg::ACR_AMP0_BIT] &&
                    acr_q[afs_pkg::ACR_AMP1_BIT];
  assign free_run = ctrl_q[afs_pkg::CTRL_FREE_BIT];
  assign avg_on = mr_q[afs_pkg::MR_AVG_BIT];
  assign last_ch = mr_q[afs_pkg::MR_LAST_LSB +: 4];
  assign trk_len = 5'(afs_pkg::TRACK_MIN) +
                   5'(mr_q[afs_pkg::MR_TRK_LSB +: 4]);
  // averaging repeats the conversion 2**ratio times
  assign conv_len = avg_on ? 12'(afs_pkg::CONV_TICKS) <<
                      mr_q[afs_pkg::MR_OSR_LSB +: 3]
                    : 12'(afs_pkg::CONV_TICKS);
  // start only when tracking is long enough and the converter frees up
  assign fire = tick && st_q == afs_pkg::ST_TRACK &&
                trk_cnt_q >= trk_len && conv_cnt_q <= 12'd1;
  assign conv_end = tick && conv_cnt_q == 12'd1;
  assign xfer_done = tick &&
                     xfer_cnt_q == 2'(afs_pkg::XFER_TICKS - 1);
  assign busy = st_q != afs_pkg::ST_IDLE || conv_cnt_q != 12'd0;

  afs_prescaler #(.W(8)) u_div (
    .clk(clk),
    .rst(rst),
    .div(mr_q[afs_pkg::MR_DIV_LSB +: 8]),
    .tick(tick)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= conv_data;
      sync_q <= meta_q;
    end
  end

  // start request ignored while the amplifiers are off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) start_q <= 1'b0;
    else if (wr_en && waddr_q == afs_pkg::OFS_CTRL && wstrb_q[0] &&
             wdata_q[afs_pkg::CTRL_START_BIT] && gains_on)
      start_q <= 1'b1;
    else if (tick && st_q == afs_pkg::ST_IDLE)
      start_q <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= afs_pkg::ST_IDLE;
      chan_q <= '0;
      trk_cnt_q <= '0;
      xfer_cnt_q <= '0;
    end else if (tick) begin
      unique case (st_q)
        afs_pkg::ST_IDLE: begin
          if (start_q || (free_run && gains_on)) begin
            st_q <= afs_pkg::ST_TRACK;
            chan_q <= '0;
            trk_cnt_q <= '0;
          end
        end
        afs_pkg::ST_TRACK: begin
          if (trk_cnt_q != 5'h1F) trk_cnt_q <= trk_cnt_q + 5'd1;
          if (fire) begin
            st_q <= afs_pkg::ST_XFER;
            xfer_cnt_q <= '0;
          end
        end
        afs_pkg::ST_XFER: begin
          xfer_cnt_q <= xfer_cnt_q + 2'd1;
          // channel held until the transfer time is over
          if (xfer_done) begin
            trk_cnt_q <= '0;
            if (chan_q != last_ch) begin
              st_q <= afs_pkg::ST_TRACK;
              chan_q <= chan_q + 4'd1;
            end else if (free_run) begin
              st_q <= afs_pkg::ST_TRACK;
              chan_q <= '0;
            end else begin
              st_q <= afs_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_cnt_q <= '0;
      conv_ch_q <= '0;
    end else if (fire) begin
      conv_cnt_q <= conv_len;
      conv_ch_q <= chan_q;
    end else if (tick && conv_cnt_q != 12'd0) begin
      conv_cnt_q <= conv_cnt_q - 12'd1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_q <= '0;
      data_ch_q <= '0;
    end else if (conv_end) begin
      data_q <= sync_q;
      data_ch_q <= conv_ch_q;
    end
  end

  afs_compare #(.W(DW)) u_cmp (
    .clk(clk),
    .rst(rst),
    .data(sync_q),
    .threshold(cmp_q[DW-1:0]),
    .enable(cmp_q[afs_pkg::CMP_EN_BIT]),
    .valid(conv_end),
    .match(match)
  );

  ////////////////////////////////////////////////////////////////////////
  // status, interrupt, outputs
  // a new event wins over the read that clears it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) sts_q <= '0;
    else begin
      sts_q[afs_pkg::STS_EOC_BIT] <= conv_end ||
        (sts_q[afs_pkg::STS_EOC_BIT] && !(rd_hs &&
         raddr == afs_pkg::OFS_STS));
      sts_q[afs_pkg::STS_MATCH_BIT] <= match ||
        (sts_q[afs_pkg::STS_MATCH_BIT] && !(rd_hs &&
         raddr == afs_pkg::OFS_STS));
      sts_q[afs_pkg::STS_BUSY_BIT] <= busy;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
      fault <= 1'b0;
      afe_start <= 1'b0;
      afe_channel <= '0;
    end else begin
      irq <= |(sts_q[1:0] & mask_q[1:0]);
      fault <= sts_q[afs_pkg::STS_MATCH_BIT];
      afe_start <= fire;
      afe_channel <= chan_q;
    end
  end

  a_track_min: assert property (@(posedge clk) disable iff (rst)
    fire |-> trk_cnt_q >= 5'(afs_pkg::TRACK_MIN))
    else $error("converter started before minimum tracking");
  a_conv_len: assert property (@(posedge clk) disable iff (rst)
    fire && !avg_on |=> conv_cnt_q == 12'd23)
    else $error("single conversion not twenty-three periods");
  a_avg_len: assert property (@(posedge clk) disable iff (rst)
    fire && avg_on |=> conv_cnt_q == 12'd23 << $past(mr_q[19:17]))
    else $error("averaged conversion length wrong");
  a_xfer_hold: assert property (@(posedge clk) disable iff (rst)
    st_q == afs_pkg::ST_XFER && !xfer_done |=> $stable(chan_q))
    else $error("channel changed during transfer time");
  a_track_overlap: assert property (@(posedge clk) disable iff (rst)
    st_q == afs_pkg::ST_XFER && xfer_done ##1 st_q == afs_pkg::ST_TRACK
      |-> conv_cnt_q != 12'd0)
    else $error("tracking did not overlap conversion");
  a_track_stretch: assert property (@(posedge clk) disable iff (rst)
    fire |-> conv_cnt_q <= 12'd1)
    else $error("start while previous conversion running");
  a_fault_out: assert property (@(posedge clk) disable iff (rst)
    sts_q[afs_pkg::STS_MATCH_BIT] |=> fault)
    else $error("fault output missed a match");
endmodule // afs_sequencer
`default_nettype wire

/* sim/afs_core_model.sv */
// afs_core_model: behavioural converter core and pwm fault input
`default_nettype none
module afs_core_model #(
  parameter logic [11:0] RES_BASE = 12'h5A0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic afe_start,
  input wire logic [3:0] afe_channel,
  input wire logic fault,
  output logic [11:0] conv_data,
  output logic pwm_halt
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  logic [3:0] ch_q;
  // result settles a few clocks after start; garbage meanwhile, so a
  // sequencer that samples too early reads a wrong value
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_data <= 12'hA5A;
      cnt <= 0;
      ch_q <= 4'h0;
    end else if (afe_start) begin
      conv_data <= ~conv_data;
      ch_q <= afe_channel;
      cnt <= 4;
    end else if (cnt == 1) begin
      conv_data <= RES_BASE + 12'({ch_q, 4'h0});
      cnt <= 0;
    end else if (cnt > 1) begin
      conv_data <= ~conv_data;
      cnt <= cnt - 1;
    end
  end
  assign pwm_halt = fault;
endmodule // afs_core_model
`default_nettype wire

/* sim/afs_sequencer_tb.sv */
// afs_sequencer_tb: self-checking bench for the conversion sequencer
`default_nettype none
module afs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [1:0] OK = afs_pkg::RESP_OKAY;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic afe_start, irq, fault, pwm_halt;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [11:0] conv_data;
  logic [3:0] afe_channel;
  logic [3:0] ch_prev = 4'h0;
  logic [3:0] chans[$];
  int starts[$];
  int chg[$];
  int cyc = 0;
  int n_fail = 0;
  int compares = 0;

  always #10 clk = ~clk;

  afs_sequencer afs_sequencer_inst (.clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conv_data(conv_data), .afe_channel(afe_channel),
    .afe_start(afe_start), .irq(irq), .fault(fault));

  afs_core_model afs_core_model_inst (.clk(clk), .rst(rst),
    .afe_start(afe_start), .afe_channel(afe_channel), .fault(fault),
    .conv_data(conv_data), .pwm_halt(pwm_halt));

  // start times, channel at each start, times of channel changes
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ch_prev <= afe_channel;
    if (afe_start === 1'b1) begin
      starts.push_back(cyc);
      chans.push_back(afe_channel);
    end
    if (afe_channel !== ch_prev) chg.push_back(cyc);
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic give_up();
    check(32'h0000_0000, ONE);
    stop_test();
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (n > 2000) give_up();
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check(32'(bresp), 32'(er));
    @(posedge clk);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (n > 2000) give_up();
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(d, e);
  endtask

  task automatic wait_starts(input int k);
    int n;
    n = 0;
    while (starts.size() < k) begin
      @(posedge clk);
      n++;
      if (n > 20000) give_up();
    end
  endtask

  // polling clears the sticky status bits as a side effect
  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    d = 32'hFFFF_FFFF;
    while (d[afs_pkg::STS_BUSY_BIT] !== 1'b0) begin
      axi_read(afs_pkg::OFS_STS, d, r);
      n++;
      if (n > 5000) give_up();
    end
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 5000) give_up();
    end
  endtask

  function automatic int first_after(input int t);
    foreach (chg[i]) if (chg[i] > t) return chg[i];
    return 0;
  endfunction

  task automatic run(input logic [31:0] mr, input logic [31:0] ctl,
                     input int k);
    starts.delete();
    chans.delete();
    chg.delete();
    axi_write(afs_pkg::OFS_MR, mr, OK);
    axi_write(afs_pkg::OFS_CTRL, ctl, OK);
    wait_starts(k);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] zo[4] = '{afs_pkg::OFS_CTRL, afs_pkg::OFS_ACR,
                          afs_pkg::OFS_CMP, afs_pkg::OFS_MASK};
    logic [31:0] d;
    logic [1:0] r;
    rd_check(afs_pkg::OFS_MR, afs_pkg::MR_RST);
    foreach (zo[i]) rd_check(zo[i], afs_pkg::ZERO_RST);
    axi_read(8'h1C, d, r);
    check(d, afs_pkg::ZERO_RST);
    check(32'(r), 32'(afs_pkg::RESP_SLVERR));
    axi_write(8'h1C, 32'hFFFF_FFFF, afs_pkg::RESP_SLVERR);
    axi_write(afs_pkg::OFS_MR, 32'hFFFF_FFFF, OK);
    rd_check(afs_pkg::OFS_MR, afs_pkg::MR_MASK);
  endtask

  // amplifiers still off: a start request must be ignored
  task automatic t_refuse();
    run(32'h0000_0000, ONE, 0);
    repeat (300) @(posedge clk);
    check(32'(starts.size()), 32'h0000_0000);
  endtask

  task automatic t_scan(input int div);
    int p;
    int c;
    p = div + 1;
    run(32'(div) | 32'h0010_0000, ONE, 2);
    c = first_after(starts[0]);
    check(32'(starts[1] - starts[0]), 32'(23 * p));
    check(32'(chans[0]), 32'h0000_0000);
    check(32'(chans[1]), ONE);
    check(32'(c - starts[0] >= 2 * p - 2), ONE);
    check(32'(starts[1] - c >= 15 * p), ONE);
    check(32'(c > 0 && c < starts[1]), ONE);
    wait_idle();
    rd_check(afs_pkg::OFS_DATA, 32'h0001_05B0);
  endtask

  task automatic t_avg(input int oversampling_ratio);
    run(32'h0011_0000 | (32'(oversampling_ratio) << afs_pkg::MR_OSR_LSB), ONE, 2);
    check(32'(starts[1] - starts[0]), 32'(23 << oversampling_ratio));
    wait_idle();
  endtask

  task automatic t_long();
    run(32'h0010_0F00, ONE, 2);
    check(32'(starts[1] - starts[0] >= 32), ONE);
    check(32'(starts[1] - first_after(starts[0]) >= 30), ONE);
    wait_idle();
  endtask

  task automatic t_free();
    run(32'h0000_0000, 32'h0000_0003, 3);
    check(32'(starts[1] - starts[0]), 32'h0000_0017);
    check(32'(starts[2] - starts[1]), 32'h0000_0017);
    axi_write(afs_pkg::OFS_CTRL, 32'h0000_0000, OK);
    wait_idle();
  endtask

  task automatic t_cmp();
    axi_write(afs_pkg::OFS_MASK, 32'h0000_0003, OK);
    axi_write(afs_pkg::OFS_CMP, 32'h0000_0100, OK);
    run(32'h0000_0000, ONE, 1);
    wait_irq();
    rd_check(afs_pkg::OFS_STS, ONE);
    check(32'(fault), 32'h0000_0000);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0000_0000);
    rd_check(afs_pkg::OFS_DATA, 32'h0000_05A0);
    axi_write(afs_pkg::OFS_CMP, 32'h0001_0100, OK);
    run(32'h0000_0000, ONE, 1);
    wait_irq();
    repeat (2) @(posedge clk);
    check(32'(fault), ONE);
    check(32'(pwm_halt), ONE);
    rd_check(afs_pkg::OFS_STS, 32'h0000_0003);
    repeat (3) @(posedge clk);
    check(32'(fault), 32'h0000_0000);
    check(32'(irq), 32'h0000_0000);
    // masked: status latches but the line stays low
    axi_write(afs_pkg::OFS_MASK, 32'h0000_0000, OK);
    run(32'h0000_0000, ONE, 1);
    repeat (40) @(posedge clk);
    check(32'(irq), 32'h0000_0000);
    rd_check(afs_pkg::OFS_STS, 32'h0000_0003);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_refuse();
    axi_write(afs_pkg::OFS_ACR, 32'h0000_0003, OK);
    t_scan(1);
    t_scan(3);
    t_scan(255);
    t_avg(1);
    t_avg(2);
    t_long();
    t_free();
    t_cmp();
    stop_test();
  end
endmodule // afs_sequencer_tb
`default_nettype wire
